// ==== core/lvdc_pkg.sv ====
/*
   Constants for the supply monitor control block: register offsets,
   field positions, reset values and the summary of operation.
   Assumes a single 25 MHz bus clock and an 8-bit register port.
*/
// Summary of operation
// - Undervoltage events are recognised only while detect enable is set.
// - In stop mode detection is off unless the stop enable bit is set.
// - After power-on reset the system stays in reset while supply is low.
// - A power-on reset sets both power-on and low-voltage cause flags.
// - With reset enable set, a detected low supply forces system reset.
// - A low-voltage reset holds until supply recovers, then sets its cause.
// - With detect and irq enable set and reset enable clear, flag and irq.
// - The flag reads at bit 7 and reports only while detection is enabled.
// - Writing 1 to bit 6 clears the flag unless an event sets it in the same cycle; bit 6 always reads as zero.
// - Bit 5 set requests an interrupt whenever the flag is set.
// - Bit 4 is write-once reset enable, effective only with detection on.
// - Bit 3 is a read/write stop-mode detection enable.
// - Bit 2 is write-once detect enable and qualifies bits 7, 4 and 3.
// - Bit 0 enables the reference buffer of the analog comparator.
// - Write-once bits accept the first write after reset only.
package lvdc_pkg;
   localparam logic [3:0] OFS_SMSC     = 4'h0;
   localparam logic [3:0] OFS_CAUSE    = 4'h1;
   localparam int         BIT_FLAG     = 7;
   localparam int         BIT_ACK      = 6;
   localparam int         BIT_IRQEN    = 5;
   localparam int         BIT_RSTEN    = 4;
   localparam int         BIT_STOPEN   = 3;
   localparam int         BIT_DETEN    = 2;
   localparam int         BIT_REFBUF   = 0;
   localparam int         CAUSE_LV     = 1;
   localparam int         CAUSE_POR    = 7;
   localparam logic [7:0] SMSC_RST     = 8'h00;
   localparam logic [7:0] ZERO8        = 8'h00;
endpackage

// ==== core/lvdc_core.sv ====
/*
   Supply monitor control: flag, interrupt, reset hold and cause bits.
   Assumes detector levels arrive asynchronously and are synchronised
   here; rst is a synchronous system reset that this block may request.
*/
`timescale 1ns/10ps
module lvdc_core
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       clkEn,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   input  wire logic       porActive,
   input  wire logic       supplyLow,
   input  wire logic       stopMode,
   output logic            sysResetReq,
   output logic            undervoltageIrq,
   output logic            referenceBufferEnable,
   output logic            detectorActive
);
   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   logic [1:0] porSync_ff;
   logic [1:0] lowSync_ff;
   logic       porS;
   logic       lowS;
   always_ff @(posedge ref_clk)
   begin
      if (clkEn)
      begin
         porSync_ff <= {porSync_ff[0], porActive};
         lowSync_ff <= {lowSync_ff[0], supplyLow};
      end
   end
   assign porS = porSync_ff[1];
   assign lowS = lowSync_ff[1];

   // ---------------------------------------------
   // Control register
   // ---------------------------------------------
   logic irqEn_ff;
   logic rstEn_ff;
   logic stopEn_ff;
   logic detEn_ff;
   logic refBuf_ff;
   logic rstEnLocked_ff;
   logic detEnLocked_ff;
   logic flag_ff;
   logic wrCtl;
   logic detecting;
   logic lowEvent;
   assign wrCtl = regWr && (regAddr == lvdc_pkg::OFS_SMSC);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         irqEn_ff  <= 1'b0;
         stopEn_ff <= 1'b0;
         refBuf_ff <= 1'b0;
      end
      else if (clkEn && wrCtl)
      begin
         irqEn_ff  <= regWrData[lvdc_pkg::BIT_IRQEN];
         stopEn_ff <= regWrData[lvdc_pkg::BIT_STOPEN];
         refBuf_ff <= regWrData[lvdc_pkg::BIT_REFBUF];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rstEn_ff       <= 1'b0;
         detEn_ff       <= 1'b0;
         rstEnLocked_ff <= 1'b0;
         detEnLocked_ff <= 1'b0;
      end
      else if (clkEn && wrCtl)
      begin
         rstEnLocked_ff <= 1'b1;
         detEnLocked_ff <= 1'b1;
         if (!rstEnLocked_ff)
            rstEn_ff <= regWrData[lvdc_pkg::BIT_RSTEN];
         if (!detEnLocked_ff)
            detEn_ff <= regWrData[lvdc_pkg::BIT_DETEN];
      end
   end

   // ---------------------------------------------
   // Detection and flag
   // ---------------------------------------------
   assign detecting = detEn_ff && (!stopMode || stopEn_ff);
   assign lowEvent  = detecting && lowS;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         flag_ff <= 1'b0;
      else if (clkEn)
      begin
         if (lowEvent && !rstEn_ff)
            flag_ff <= 1'b1;
         else if (wrCtl && regWrData[lvdc_pkg::BIT_ACK])
            flag_ff <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Reset request and cause flags
   // ---------------------------------------------
   logic holdPor_ff;
   logic holdLv_ff;
   logic causePor_ff;
   logic causeLv_ff;
   logic wrCause;
   assign wrCause = regWr && (regAddr == lvdc_pkg::OFS_CAUSE);

   // Holds survive rst since they produce it
   always_ff @(posedge ref_clk)
   begin
      if (clkEn)
      begin
         if (porS)
            holdPor_ff <= 1'b1;
         else if (!lowS)
            holdPor_ff <= 1'b0;
         if (porS)
            holdLv_ff <= 1'b0;
         else if (lowEvent && rstEn_ff)
            holdLv_ff <= 1'b1;
         else if (!lowS)
            holdLv_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (clkEn)
      begin
         if (porS)
         begin
            causePor_ff <= 1'b1;
            causeLv_ff  <= 1'b1;
         end
         else if (holdLv_ff && !lowS)
         begin
            causePor_ff <= 1'b0;
            causeLv_ff  <= 1'b1;
         end
         else if (wrCause)
         begin
            causePor_ff <= 1'b0;
            causeLv_ff  <= 1'b0;
         end
      end
   end

   assign sysResetReq           = porS || holdPor_ff || holdLv_ff;
   assign undervoltageIrq       = flag_ff && irqEn_ff;
   assign referenceBufferEnable = refBuf_ff;
   assign detectorActive        = detecting;

   // ---------------------------------------------
   // Read port
   // ---------------------------------------------
   logic [7:0] nxt_rd;
   always_comb
   begin
      nxt_rd = lvdc_pkg::ZERO8;
      if (regAddr == lvdc_pkg::OFS_SMSC)
      begin
         nxt_rd[lvdc_pkg::BIT_FLAG]   = flag_ff && detEn_ff;
         nxt_rd[lvdc_pkg::BIT_IRQEN]  = irqEn_ff;
         nxt_rd[lvdc_pkg::BIT_RSTEN]  = rstEn_ff;
         nxt_rd[lvdc_pkg::BIT_STOPEN] = stopEn_ff;
         nxt_rd[lvdc_pkg::BIT_DETEN]  = detEn_ff;
         nxt_rd[lvdc_pkg::BIT_REFBUF] = refBuf_ff;
      end
      else if (regAddr == lvdc_pkg::OFS_CAUSE)
      begin
         nxt_rd[lvdc_pkg::CAUSE_POR] = causePor_ff;
         nxt_rd[lvdc_pkg::CAUSE_LV]  = causeLv_ff;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         regRdData <= lvdc_pkg::SMSC_RST;
      else if (clkEn && regRd)
         regRdData <= nxt_rd;
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   chk_ack_reads_zero: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && regRd |=> !regRdData[lvdc_pkg::BIT_ACK])
      else $error("ack bit read as one");
   chk_irq_follows_flag: assert property (@(posedge ref_clk)
      undervoltageIrq == (flag_ff && irqEn_ff))
      else $error("irq not tied to flag");
   chk_no_event_off: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && !detEn_ff && !flag_ff |=> !flag_ff)
      else $error("flag set while detection off");
   chk_stop_gate: assert property (@(posedge ref_clk)
      stopMode && !stopEn_ff |-> !detectorActive)
      else $error("detection active in stop");
   chk_lv_reset: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && lowEvent && rstEn_ff |=> sysResetReq)
      else $error("no reset on low supply");
   chk_por_hold: assert property (@(posedge ref_clk)
      clkEn && porS ##1 clkEn && lowS |=> sysResetReq)
      else $error("reset released while supply low");
   chk_por_cause: assert property (@(posedge ref_clk)
      clkEn && porS |=> causePor_ff && causeLv_ff)
      else $error("cause flags not set by power-on");
   chk_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && lowEvent && !rstEn_ff |=> flag_ff)
      else $error("flag not set on event");
   chk_ack_clears: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && wrCtl && regWrData[lvdc_pkg::BIT_ACK] && !lowEvent
      |=> !flag_ff)
      else $error("flag not cleared by ack");
   chk_rsten_locked: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && wrCtl && rstEnLocked_ff |=> $stable(rstEn_ff))
      else $error("reset enable written twice");
   chk_deten_locked: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && wrCtl && detEnLocked_ff |=> $stable(detEn_ff))
      else $error("detect enable written twice");
   chk_flag_masked: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && regRd && !detEn_ff && (regAddr == lvdc_pkg::OFS_SMSC)
      |=> !regRdData[lvdc_pkg::BIT_FLAG])
      else $error("flag read while detection off");
   chk_lv_cause: assert property (@(posedge ref_clk)
      clkEn && holdLv_ff && !lowS && !porS |=> causeLv_ff)
      else $error("low voltage cause not set");
endmodule

// ==== verif/lvdc_detector_model.sv ====
/*
   Model of the analog power-on and trip-level detectors.
   Assumes the bench commands the supply state; outputs are async levels.
*/
`timescale 1ns/10ps
module lvdc_detector_model
#(
   parameter int LAG_NS = 3
)
(
   input  wire logic vddOff,
   input  wire logic vddLow,
   output logic      porActive,
   output logic      supplyLow
);
   // Below the power-on level is below the trip level too
   assign #(LAG_NS) porActive = vddOff;
   assign #(LAG_NS) supplyLow = vddOff | vddLow;
endmodule

// ==== verif/test_low_voltage_detect_control.sv ====
/*
   Self-checking bench for the supply monitor control block.
   Assumes the detector model file and the design files are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
   begin \
      @(negedge ref_clk); \
      nChecks++; \
      if ((gt) !== (ex)) \
      begin \
         errTotal++; \
         $display("wrong value %s exp %h got %h", nm, ex, gt); \
      end \
      @(posedge ref_clk); \
   end
module test_low_voltage_detect_control;
   logic       ref_clk;
   logic       rst;
   logic       clkEn;
   logic [3:0] regAddr;
   logic [7:0] regWrData;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdData;
   logic       porActive;
   logic       supplyLow;
   logic       stopMode;
   logic       sysResetReq;
   logic       undervoltageIrq;
   logic       referenceBufferEnable;
   logic       detectorActive;
   logic       vddOff;
   logic       vddLow;
   int         errTotal;
   int         nChecks;

   lvdc_core uut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .porActive(porActive),
      .supplyLow(supplyLow), .stopMode(stopMode),
      .sysResetReq(sysResetReq), .undervoltageIrq(undervoltageIrq),
      .referenceBufferEnable(referenceBufferEnable),
      .detectorActive(detectorActive));
   lvdc_detector_model partner (.vddOff(vddOff), .vddLow(vddLow),
      .porActive(porActive), .supplyLow(supplyLow));

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] ex);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      `CHK("read data", ex, regRdData)
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      #80000;
      errTotal++;
      close_out;
   end
   initial
   begin
      errTotal = 0;
      nChecks = 0;
      rst = 1'b1;
      clkEn = 1'b1;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      stopMode = 1'b0;
      vddOff = 1'b1;
      vddLow = 1'b1;
      tick(8);
      rst <= 1'b0;
      vddOff <= 1'b0;
      tick(4);
      `CHK("hold", 1'b1, sysResetReq)
      vddLow <= 1'b0;
      tick(6);
      `CHK("hold", 1'b0, sysResetReq)
      rd(4'h1, 8'h82);
      wr(4'h1, 8'hFF);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h2F);
      rd(4'h0, 8'h2D);
      `CHK("buffer", 1'b1, referenceBufferEnable)
      wr(4'h0, 8'h10);
      rd(4'h0, 8'h04);
      `CHK("buffer", 1'b0, referenceBufferEnable)
      wr(4'h0, 8'h29);
      vddLow <= 1'b1;
      tick(6);
      `CHK("irq", 1'b1, undervoltageIrq)
      `CHK("reset", 1'b0, sysResetReq)
      rd(4'h0, 8'hAD);
      tick(1);
      vddLow <= 1'b0;
      tick(5);
      wr(4'h0, 8'h69);
      rd(4'h0, 8'h2D);
      `CHK("irq", 1'b0, undervoltageIrq)
      tick(1);
      stopMode <= 1'b1;
      vddLow <= 1'b1;
      tick(6);
      rd(4'h0, 8'hAD);
      tick(1);
      vddLow <= 1'b0;
      tick(5);
      wr(4'h0, 8'h61);
      vddLow <= 1'b1;
      tick(6);
      `CHK("active", 1'b0, detectorActive)
      rd(4'h0, 8'h25);
      tick(1);
      stopMode <= 1'b0;
      tick(6);
      rd(4'h0, 8'hA5);
      rd(4'h5, 8'h00);
      tick(1);
      rst <= 1'b1;
      tick(8);
      rst <= 1'b0;
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h20);
      tick(6);
      rd(4'h0, 8'h20);
      `CHK("irq", 1'b0, undervoltageIrq)
      tick(1);
      rst <= 1'b1;
      tick(8);
      rst <= 1'b0;
      wr(4'h0, 8'h14);
      tick(6);
      `CHK("reset", 1'b1, sysResetReq)
      rst <= 1'b1;
      tick(8);
      rst <= 1'b0;
      tick(2);
      `CHK("hold", 1'b1, sysResetReq)
      vddLow <= 1'b0;
      tick(6);
      `CHK("hold", 1'b0, sysResetReq)
      rd(4'h1, 8'h02);
      clkEn <= 1'b0;
      wr(4'h1, 8'hFF);
      clkEn <= 1'b1;
      rd(4'h1, 8'h02);
      close_out;
   end
endmodule
